/* verilog/mis_map.svh */
/*
  register offsets, flag positions and reset values of the monitor
  interrupt status block. assumes it is included by bare name.
*/
`ifndef MIS_MAP_SVH
`define MIS_MAP_SVH

`define MIS_STATUS_FIRST_ADDR 8'h41
`define MIS_STATUS_SECOND_ADDR 8'h42
`define MIS_STATUS_RESET 8'h00

// first status register
`define MIS_S1_V25_BIT 0
`define MIS_S1_VCCP_BIT 1
`define MIS_S1_VCC_BIT 2
`define MIS_S1_V5_BIT 3
`define MIS_S1_REMOTE_ONE_BIT 4
`define MIS_S1_LOCAL_BIT 5
`define MIS_S1_REMOTE_TWO_BIT 6
`define MIS_S1_CHAIN_BIT 7

// second status register
`define MIS_S2_V12_BIT 0
`define MIS_S2_CHAIN_BIT 1
`define MIS_S2_FAN_ONE_BIT 2
`define MIS_S2_FAN_FOUR_BIT 5
`define MIS_S2_DIODE_ONE_BIT 6
`define MIS_S2_DIODE_TWO_BIT 7

// channel indices into the voltage and temperature arrays
`define MIS_VOLT_V12 4
`define MIS_TEMP_REMOTE_ONE 0
`define MIS_TEMP_LOCAL 1
`define MIS_TEMP_REMOTE_TWO 2

`endif

/* verilog/mis_pkg.sv */
/*
  types shared by the monitor interrupt status block.
  assumes nothing of its surroundings.
*/
`default_nettype none
package mis_pkg;

  typedef logic [7:0] mis_byte_t;

  // one measured channel with its window limits
  typedef struct packed {
    logic [7:0] reading;
    logic [7:0] high_limit;
    logic [7:0] low_limit;
  } mis_chan_s;

  // one tachometer period count with its limit
  typedef struct packed {
    logic [15:0] count;
    logic [15:0] minimum;
  } mis_fan_s;

  // register read port from the two-wire slave
  typedef struct packed {
    logic rd_en;
    logic [7:0] rd_addr;
  } mis_read_s;

endpackage
`default_nettype wire

/* verilog/mis_limit_cmp.sv */
/*
  window comparator for one monitored channel: high side is strictly
  greater, low side is equal or below.
  assumes reading and limits come from logic on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module mis_limit_cmp
  import mis_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter bit IS_SIGNED = 1'b0
) (
  input wire logic [WIDTH-1:0] reading_i,
  input wire logic [WIDTH-1:0] high_limit_i,
  input wire logic [WIDTH-1:0] low_limit_i,
  output logic violation_o
);

  logic high_hit;
  logic low_hit;

  always_comb begin
    if (IS_SIGNED) begin
      high_hit = $signed(reading_i) > $signed(high_limit_i);
      low_hit = $signed(reading_i) <= $signed(low_limit_i);
    end else begin
      high_hit = reading_i > high_limit_i;
      low_hit = reading_i <= low_limit_i;
    end
    violation_o = high_hit | low_hit;
  end

endmodule
`default_nettype wire

/* verilog/mis_top.sv */
/*
  two sticky interrupt status registers of a hardware monitor with
  clear-on-read, chained summary bits and an alert output.
  assumes readings, limits, fan and diode states and the register read
  strobe all come from logic on clk_i; the two-wire slave decodes the
  bus and presents one read strobe per register read.
*/
// How it works
// - first status bits 0..3 latch 2.5 V, Vccp, Vcc and 5 V window violations.
// - a read clears a latched flag only if its condition is absent at that read.
// - first status bit 4 latches a remote one temperature window violation.
// - first status bit 5 latches a local temperature window violation.
// - first status bit 6 latches a remote two temperature window violation.
// - first status bit 7 is always the OR of all second status flags.
// - second status bit 0 latches a 12 V window violation.
// - second status bit 1 is the OR of all third status flags.
// - second status bits 2..4 latch fan one..three underspeed, gated by drive on.
// - second status bit 5 latches fan four slow if tach selected and fan three drive on.
// - second status bits 6 and 7 latch diode one and two open or short faults.
// - both registers are read-only and reset to zero.
// - high violation is reading above high limit, low is reading at or below low.
`timescale 1ns/10ps
`default_nettype none
`include "mis_map.svh"
module mis_top
  import mis_pkg::*;
#(
  parameter int NUM_VOLT = 5,
  parameter int NUM_TEMP = 3,
  parameter int NUM_FAN = 4
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire mis_chan_s [NUM_VOLT-1:0] volt_i,
  input wire mis_chan_s [NUM_TEMP-1:0] temp_i,
  input wire mis_fan_s [NUM_FAN-1:0] fan_i,
  input wire logic [2:0] fan_drive_on_i,
  input wire logic fourth_tachometer_input_i,
  input wire logic [1:0] diode_fault_i,
  input wire logic [7:0] status_third_i,
  input wire logic [15:0] alert_mask_i,
  input wire mis_read_s read_i,
  output logic [7:0] rd_data_o,
  output logic alert_o
);

  // limit comparison
  logic [NUM_VOLT-1:0] volt_viol;
  logic [NUM_TEMP-1:0] temp_viol;
  logic [NUM_FAN-1:0] fan_slow;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_VOLT; gi++) begin : g_volt
      mis_limit_cmp #(
        .WIDTH(8),
        .IS_SIGNED(1'b0)
      ) u_cmp (
        .reading_i(volt_i[gi].reading),
        .high_limit_i(volt_i[gi].high_limit),
        .low_limit_i(volt_i[gi].low_limit),
        .violation_o(volt_viol[gi])
      );
    end
    for (gi = 0; gi < NUM_TEMP; gi++) begin : g_temp
      mis_limit_cmp #(
        .WIDTH(8),
        .IS_SIGNED(1'b1)
      ) u_cmp (
        .reading_i(temp_i[gi].reading),
        .high_limit_i(temp_i[gi].high_limit),
        .low_limit_i(temp_i[gi].low_limit),
        .violation_o(temp_viol[gi])
      );
    end
    for (gi = 0; gi < NUM_FAN; gi++) begin : g_fan
      // a period count above the minimum-speed limit means slow or stalled
      assign fan_slow[gi] = fan_i[gi].count > fan_i[gi].minimum;
    end
  endgenerate

  // live conditions, laid out as the register bits
  logic [7:0] cond_first;
  logic [7:0] cond_second;

  always_comb begin
    cond_first = `MIS_STATUS_RESET;
    cond_first[`MIS_S1_V25_BIT] = volt_viol[0];
    cond_first[`MIS_S1_VCCP_BIT] = volt_viol[1];
    cond_first[`MIS_S1_VCC_BIT] = volt_viol[2];
    cond_first[`MIS_S1_V5_BIT] = volt_viol[3];
    cond_first[`MIS_S1_REMOTE_ONE_BIT] = temp_viol[`MIS_TEMP_REMOTE_ONE];
    cond_first[`MIS_S1_LOCAL_BIT] = temp_viol[`MIS_TEMP_LOCAL];
    cond_first[`MIS_S1_REMOTE_TWO_BIT] = temp_viol[`MIS_TEMP_REMOTE_TWO];
    cond_second = `MIS_STATUS_RESET;
    cond_second[`MIS_S2_V12_BIT] = volt_viol[`MIS_VOLT_V12];
    for (int i = 0; i < 3; i++) begin
      cond_second[`MIS_S2_FAN_ONE_BIT + i] = fan_slow[i] & fan_drive_on_i[i];
    end
    cond_second[`MIS_S2_FAN_FOUR_BIT] =
      fan_slow[3] & fourth_tachometer_input_i & fan_drive_on_i[2];
    cond_second[`MIS_S2_DIODE_ONE_BIT] = diode_fault_i[0];
    cond_second[`MIS_S2_DIODE_TWO_BIT] = diode_fault_i[1];
  end

  // sticky flags
  logic [7:0] flag_first;
  logic [7:0] flag_second;
  logic [7:0] next_flag_first;
  logic [7:0] next_flag_second;
  logic [7:0] view_first;
  logic [7:0] view_second;
  logic read_first;
  logic read_second;

  // a read drops only those flags whose condition is gone; a live
  // condition re-latches in the same cycle so no event is lost
  function automatic logic [7:0] sticky_next(input logic [7:0] flag,
                                             input logic [7:0] cond,
                                             input logic rd);
    if (rd) begin
      sticky_next = cond;
    end else begin
      sticky_next = flag | cond;
    end
  endfunction

  assign read_first = read_i.rd_en && (read_i.rd_addr == `MIS_STATUS_FIRST_ADDR);
  assign read_second = read_i.rd_en && (read_i.rd_addr == `MIS_STATUS_SECOND_ADDR);

  always_comb begin
    // chain bits are never stored; they are recomposed in the view
    next_flag_first = sticky_next(flag_first, cond_first, read_first);
    next_flag_first[`MIS_S1_CHAIN_BIT] = 1'b0;
    next_flag_second = sticky_next(flag_second, cond_second, read_second);
    next_flag_second[`MIS_S2_CHAIN_BIT] = 1'b0;
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      flag_first <= `MIS_STATUS_RESET;
      flag_second <= `MIS_STATUS_RESET;
    end else begin
      flag_first <= next_flag_first;
      flag_second <= next_flag_second;
    end
  end

  always_comb begin
    view_second = flag_second;
    view_second[`MIS_S2_CHAIN_BIT] = |status_third_i;
    view_first = flag_first;
    view_first[`MIS_S1_CHAIN_BIT] = |view_second;
  end

  // read data and alert
  logic [7:0] next_rd_data;
  logic next_alert;

  // no write path exists: both registers are read-only
  always_comb begin
    next_rd_data = rd_data_o;
    if (read_first) begin
      next_rd_data = view_first;
    end else if (read_second) begin
      next_rd_data = view_second;
    end else if (read_i.rd_en) begin
      next_rd_data = `MIS_STATUS_RESET;
    end
    next_alert = |({view_second, view_first} & ~alert_mask_i);
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rd_data_o <= `MIS_STATUS_RESET;
      alert_o <= 1'b0;
    end else begin
      rd_data_o <= next_rd_data;
      alert_o <= next_alert;
    end
  end

  // assertions
  a_volt_latch: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    volt_viol[0] |=> flag_first[`MIS_S1_V25_BIT])
    else $error("2.5 V violation not latched");

  a_read_keeps: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    read_first && cond_first[`MIS_S1_VCC_BIT]
    |=> flag_first[`MIS_S1_VCC_BIT])
    else $error("flag cleared while its condition held");

  a_read_clears: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    read_second && flag_second[`MIS_S2_DIODE_ONE_BIT] && !diode_fault_i[0]
    |=> !flag_second[`MIS_S2_DIODE_ONE_BIT])
    else $error("flag not cleared by read after condition left");

  a_hold_unread: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    flag_first[`MIS_S1_V5_BIT] && !read_first
    |=> flag_first[`MIS_S1_V5_BIT])
    else $error("flag dropped without a read");

  a_read_data: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    read_first |=> rd_data_o[6:0] == $past(flag_first[6:0]))
    else $error("read data is not the flags held at the read");

  a_remote_one: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    temp_viol[`MIS_TEMP_REMOTE_ONE] |=> flag_first[`MIS_S1_REMOTE_ONE_BIT])
    else $error("remote one temperature not latched");

  a_local_temp: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    temp_viol[`MIS_TEMP_LOCAL] |=> flag_first[`MIS_S1_LOCAL_BIT])
    else $error("local temperature not latched");

  a_remote_two: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    temp_viol[`MIS_TEMP_REMOTE_TWO] |=> flag_first[`MIS_S1_REMOTE_TWO_BIT])
    else $error("remote two temperature not latched");

  a_chain_first: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    read_first |=> rd_data_o[`MIS_S1_CHAIN_BIT] == $past(|view_second))
    else $error("first summary bit differs from second register");

  a_twelve_volt: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    volt_viol[`MIS_VOLT_V12] |=> flag_second[`MIS_S2_V12_BIT])
    else $error("12 V violation not latched");

  a_chain_second: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    read_second |=> rd_data_o[`MIS_S2_CHAIN_BIT] == $past(|status_third_i))
    else $error("second summary bit differs from third register");

  a_chain_live: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    read_second && status_third_i != 8'h00 |=> rd_data_o[`MIS_S2_CHAIN_BIT])
    else $error("second summary bit clear with third register set");

  a_fan_gated: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !fan_drive_on_i[0] && !flag_second[`MIS_S2_FAN_ONE_BIT]
    |=> !flag_second[`MIS_S2_FAN_ONE_BIT])
    else $error("fan one flag set with its drive off");

  a_fan_one_latch: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    fan_i[0].count > fan_i[0].minimum && fan_drive_on_i[0]
    |=> flag_second[`MIS_S2_FAN_ONE_BIT])
    else $error("slow fan one not latched");

  a_fan_four_sel: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (!fourth_tachometer_input_i || !fan_drive_on_i[2])
    && !flag_second[`MIS_S2_FAN_FOUR_BIT]
    |=> !flag_second[`MIS_S2_FAN_FOUR_BIT])
    else $error("fan four flag set while not selected or drive off");

  a_fan_four_latch: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    fan_i[3].count > fan_i[3].minimum && fourth_tachometer_input_i
    && fan_drive_on_i[2]
    |=> flag_second[`MIS_S2_FAN_FOUR_BIT])
    else $error("slow fan four not latched");

  a_diode_one: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    diode_fault_i[0] |=> flag_second[`MIS_S2_DIODE_ONE_BIT])
    else $error("diode one fault not latched");

  a_diode_two: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    diode_fault_i[1] |=> flag_second[`MIS_S2_DIODE_TWO_BIT])
    else $error("diode two fault not latched");

  a_reset_zero: assert property (@(posedge clk_i)
    !reset_n_i |=> flag_first == 8'h00 && flag_second == 8'h00 && !alert_o)
    else $error("status not zero after reset");

  a_high_cmp: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    volt_i[1].reading > volt_i[1].high_limit |=> flag_first[`MIS_S1_VCCP_BIT])
    else $error("reading above high limit not flagged");

  a_low_equal: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    volt_i[0].reading == volt_i[0].low_limit |=> flag_first[`MIS_S1_V25_BIT])
    else $error("reading at low limit not flagged");

  a_alert_raise: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    flag_first[`MIS_S1_V25_BIT] && !alert_mask_i[0] |=> alert_o)
    else $error("unmasked flag did not raise alert");

  a_alert_drop: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    flag_first == 8'h00 && flag_second == 8'h00 && status_third_i == 8'h00
    |=> !alert_o)
    else $error("alert stays up with all flags clear");

  c_read_clear: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    flag_first[`MIS_S1_V25_BIT] && read_first && !volt_viol[0]
    ##1 !flag_first[`MIS_S1_V25_BIT]);

  c_read_sticky: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    read_second && cond_second[`MIS_S2_FAN_ONE_BIT] ##1 flag_second[`MIS_S2_FAN_ONE_BIT]);

  c_chain_set: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    read_first ##1 rd_data_o[`MIS_S1_CHAIN_BIT]);

  c_alert_cycle: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    alert_o ##[1:20] !alert_o);

  c_fan_four_seen: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    fourth_tachometer_input_i && fan_slow[3] ##1 flag_second[`MIS_S2_FAN_FOUR_BIT]);

endmodule
`default_nettype wire

/* testbench/testbench.sv */
/*
  self-checking bench for the monitor interrupt status block: drives the
  conditions and the read strobe, checks read data and the alert output.
  assumes mis_pkg and mis_top are compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench
  import mis_pkg::*;
;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  mis_chan_s [4:0] volt;
  mis_chan_s [2:0] temp;
  mis_fan_s [3:0] fan;
  logic [2:0] drv;
  logic fourth_tachometer_input;
  logic [1:0] diode;
  logic [7:0] third;
  logic [15:0] mask;
  mis_read_s rdq;
  logic [7:0] rd_data;
  logic alert;
  int n_errors = 0;
  int compares = 0;
  logic [7:0] e;

  always #2 clk_i = ~clk_i;

  mis_top DUT (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .volt_i(volt),
    .temp_i(temp),
    .fan_i(fan),
    .fan_drive_on_i(drv),
    .fourth_tachometer_input_i(fourth_tachometer_input),
    .diode_fault_i(diode),
    .status_third_i(third),
    .alert_mask_i(mask),
    .read_i(rdq),
    .rd_data_o(rd_data),
    .alert_o(alert)
  );

  task automatic wrap_up();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s: got %b expected %b", $time, what, got, exp);
    end
  endtask

  // one strobe taken at the next rising edge; data sampled a cycle later
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
    rdq.rd_en = 1'b1;
    rdq.rd_addr = a;
    @(negedge clk_i);
    rdq.rd_en = 1'b0;
    @(negedge clk_i);
    chk_byte(rd_data, exp, what);
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // condition k: 0..3 low voltages, 4..6 temperatures, 7 twelve volt,
  // 8..11 fans, 12..13 diodes; boundary values alternate high and low side
  task automatic set_cond(input int k, input logic on);
    if (k < 4) volt[k].reading = on ? (k[0] ? 8'hF1 : 8'h10) : 8'h80;
    else if (k < 7) temp[k-4].reading = on ? (k[0] ? 8'hC0 : 8'h41) : 8'h00;
    else if (k == 7) volt[4].reading = on ? 8'hF1 : 8'h80;
    else if (k < 12) fan[k-8].count = on ? 16'h1001 : 16'h0100;
    else diode[k-12] = on;
  endtask

  function automatic logic [7:0] addr_of(input int k);
    return (k < 7) ? 8'h41 : 8'h42;
  endfunction

  function automatic logic [7:0] mask_of(input int k);
    return 8'h01 << ((k < 7) ? k : (k == 7) ? 0 : k - 6);
  endfunction

  initial begin
    for (int i = 0; i < 5; i++) volt[i] = '{8'h80, 8'hF0, 8'h10};
    for (int i = 0; i < 3; i++) temp[i] = '{8'h00, 8'h40, 8'hC0};
    for (int i = 0; i < 4; i++) fan[i] = '{16'h0100, 16'h1000};
    drv = 3'b111;
    fourth_tachometer_input = 1'b1;
    diode = 2'b00;
    third = 8'h00;
    mask = 16'h0000;
    rdq = '0;
    repeat (6) @(negedge clk_i);
    reset_n_i = 1'b1;
    chk_bit(alert, 1'b0, "alert after reset");
    rd_chk(8'h41, 8'h00, "first after reset");
    rd_chk(8'h42, 8'h00, "second after reset");
    rd_chk(8'h40, 8'h00, "unmapped below");
    rd_chk(8'h43, 8'h00, "unmapped above");
    // values on the limits that must not trip, signed temperature compare
    volt[0].reading = 8'hF0;
    volt[1].reading = 8'h11;
    temp[0].reading = 8'hC1;
    temp[1].reading = 8'h40;
    idle(3);
    rd_chk(8'h41, 8'h00, "no trip at limits");
    for (int k = 0; k < 6; k++) set_cond(k, 1'b0);
    for (int k = 0; k < 14; k++) begin
      set_cond(k, 1'b1);
      idle(3);
      chk_bit(alert, 1'b1, "alert on flag");
      e = mask_of(k);
      rd_chk(addr_of(k), e, "set");
      rd_chk(addr_of(k), e, "flag held while present");
      if (k >= 7) rd_chk(8'h41, 8'h80, "chain of second");
      set_cond(k, 1'b0);
      idle(2);
      rd_chk(addr_of(k), e, "flag kept until read");
      rd_chk(addr_of(k), 8'h00, "flag cleared");
      idle(2);
      chk_bit(alert, 1'b0, "alert off");
    end
    // fan flags suppressed by drive off and by tach pin not selected
    drv = 3'b000;
    for (int k = 8; k < 12; k++) set_cond(k, 1'b1);
    idle(3);
    rd_chk(8'h42, 8'h00, "fans gated by drive");
    fourth_tachometer_input = 1'b0;
    for (int k = 8; k < 11; k++) set_cond(k, 1'b0);
    drv = 3'b111;
    idle(3);
    rd_chk(8'h42, 8'h00, "fan four without tach pin");
    set_cond(11, 1'b0);
    fourth_tachometer_input = 1'b1;
    third = 8'h10;
    idle(2);
    rd_chk(8'h42, 8'h02, "third chain");
    rd_chk(8'h41, 8'h80, "chain to first");
    third = 8'h00;
    idle(2);
    rd_chk(8'h42, 8'h00, "third chain live");
    rd_chk(8'h41, 8'h00, "first chain live");
    idle(3);
    mask = 16'h0001;
    set_cond(0, 1'b1);
    idle(3);
    chk_bit(alert, 1'b0, "masked flag");
    mask = 16'h0000;
    idle(2);
    chk_bit(alert, 1'b1, "unmasked flag");
    set_cond(0, 1'b0);
    rd_chk(8'h41, 8'h01, "masked flag latched");
    rd_chk(8'h41, 8'h00, "masked flag cleared");
    wrap_up();
  end

  initial begin
    #20000;
    n_errors++;
    $display("BAD %0t watchdog expired", $time);
    wrap_up();
  end
endmodule
`default_nettype wire
